// *** hw/hrc_params.svh ***
// constants of the halt release controller: timing counts, levels, ids, reset values
// assumes clk is both the system clock and the oscillator clock of the core
`ifndef HRC_PARAMS_SVH
`define HRC_PARAMS_SVH

`define HRC_CLK_PERIOD_NS 50
`define HRC_OSC_PERIOD_NS 50
`define HRC_ENTRY_OSC_CLKS 3
`define HRC_ENTRY_CYC ((`HRC_ENTRY_OSC_CLKS * `HRC_OSC_PERIOD_NS + `HRC_CLK_PERIOD_NS - 1) / `HRC_CLK_PERIOD_NS)

`define HRC_NUM_MASKABLE 8
`define HRC_NMI_LEVEL 3'h7
`define HRC_SRC_NMI 4'h9
`define HRC_SRC_EXT_ZERO 4'h8
`define HRC_WARMUP_W 16

`define HRC_RST_LEVEL 3'h0
`define HRC_RST_SRC 4'h0
`define HRC_RST_CNT 2'h0
`define HRC_RST_WARMUP 16'h0000
`define HRC_RST_FLAG 1'b0
`define HRC_RST_CLK_EN 1'b1

`endif

// *** hw/hrc_pkg.sv ***
// types of the halt release controller
// assumes hrc_params.svh is on the include path
`include "hrc_params.svh"

package hrc_pkg;

  typedef enum logic [1:0] {
    HRC_MODE_RUN = 2'h0,
    HRC_MODE_LIGHT = 2'h1,
    HRC_MODE_DEEP = 2'h2,
    HRC_MODE_STOP = 2'h3
  } hrc_mode_e;

  // gray along run -> enter -> halted -> warmup -> wake
  typedef enum logic [2:0] {
    HRC_ST_RUN = 3'h0,
    HRC_ST_ENTER = 3'h1,
    HRC_ST_HALT = 3'h3,
    HRC_ST_WARM = 3'h2,
    HRC_ST_WAKE = 3'h6
  } hrc_state_e;

  typedef logic [2:0] hrc_level_t;
  typedef logic [3:0] hrc_src_t;
  typedef logic [`HRC_WARMUP_W-1:0] hrc_warm_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } hrc_sync_s;

  typedef struct packed {
    logic busy;
    logic done;
    hrc_warm_t cnt;
  } hrc_warm_s;

  typedef struct packed {
    hrc_state_e state;
    hrc_mode_e mode;
    logic [1:0] enter_cnt;
    logic nmi_prev;
    logic ez_prev;
    logic nmi_pend;
    logic ez_pend;
    logic held;
    logic svc_valid;
    hrc_src_t svc_src;
    hrc_level_t svc_level;
    logic wake_pulse;
    logic resume_pulse;
    logic halted;
    logic sysclk_en;
    logic osc_en;
    logic wu_start;
  } hrc_top_s;

endpackage

// *** hw/hrc_warm_if.sv ***
// carrier between the halt controller and its warmup counter
// assumes both ends run on the same clock
interface hrc_warm_if;
  import hrc_pkg::*;

  logic start;
  hrc_warm_t cycles;
  logic done;

  modport ctl (output start, output cycles, input done);
  modport cnt (input start, input cycles, output done);
endinterface

// *** hw/hrc_sync.sv ***
// three-stage synchroniser for a pin level; a change counts once stages two and three agree
// assumes the pin is asynchronous to clk
module hrc_sync
  import hrc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pin and settled level
  input wire logic pin,
  output logic level
);

  hrc_sync_s r;
  hrc_sync_s n;

  always_comb begin
    n = r;
    n.s1 = pin;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.level = r.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign level = r.level;

endmodule // hrc_sync

// *** hw/hrc_warmup.sv ***
// oscillator warmup counter: counts the programmed interval after a start pulse
// assumes start only arrives while idle; an interval of zero ends after one cycle
`include "hrc_params.svh"

module hrc_warmup
  import hrc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control side
  hrc_warm_if.cnt wu
);

  hrc_warm_s r;
  hrc_warm_s n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    if (wu.start) begin
      n.busy = 1'b1;
      n.cnt = wu.cycles;
    end else if (r.busy) begin
      if (r.cnt <= `HRC_WARMUP_W'(1)) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.cnt = `HRC_RST_WARMUP;
      end else begin
        n.cnt = r.cnt - `HRC_WARMUP_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign wu.done = r.done;

endmodule // hrc_warmup

// *** hw/hrc_top.sv ***
// halt release controller: decides how the core leaves run-halt, light idle, deep idle and stop
// assumes maskable requests come from same-clock logic that owns their flags; nmi and ext zero are pins
`include "hrc_params.svh"

// Operation
// RULE1 - leave any halt on a qualifying interrupt request or on reset
// RULE2 - wake sources depend on mask level together with the active halt mode
// RULE3 - maskable level above mask wakes, is serviced, then resumes after halt
// RULE4 - maskable level below mask keeps the core halted, except external zero
// RULE5 - non-maskable request always wakes and is serviced regardless of mask
// RULE6 - external zero below mask wakes without service, resuming after halt
// RULE7 - after such an unserviced wake the external zero pending flag stays one
// RULE8 - nmi or external zero during deep-idle or stop entry may not wake
// RULE9 - a request caught during that entry is held pending, not dropped
// RULE10 - later request wakes; higher priority of it and held one served first
// RULE11 - waking from deep idle or stop waits for the programmed warmup
// RULE12 - non-maskable request has fixed level seven, the highest
// RULE13 - only nmi and external zero wake from deep idle
// RULE14 - reset ends halt, keeps ram contents, initialises all other settings
module hrc_top
  import hrc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // interrupt pins
  input wire logic nmi_pin,
  input wire logic ext_irq_zero_pin,
  input wire hrc_level_t ext_irq_zero_level,
  // maskable requests from on-chip sources
  input wire logic [`HRC_NUM_MASKABLE-1:0] irq_req,
  input wire logic [`HRC_NUM_MASKABLE-1:0][2:0] irq_level,
  // core side
  input wire hrc_level_t interrupt_mask_level,
  input wire logic halt_req,
  input wire hrc_mode_e halt_mode,
  input wire logic svc_ack,
  input wire hrc_warm_t warmup_cycles,
  // halt status to the core
  output logic core_halted,
  output logic core_wake,
  output logic core_resume_next,
  // service request to the core
  output logic svc_valid,
  output hrc_src_t svc_src,
  output hrc_level_t svc_level,
  // pending flags
  output logic nmi_flag,
  output logic ext_irq_zero_flag,
  // clock controls
  output logic sysclk_en,
  output logic osc_en
);

  hrc_top_s r;
  hrc_top_s n;

  // entry length in clk cycles less one, cut to the counter's width on purpose
  localparam logic [1:0] entry_load = 2'(`HRC_ENTRY_CYC - 1);

  // pin levels after the synchronisers; an edge counts four clocks after the pin
  logic nmi_lvl;
  logic ez_lvl;

  // the warmup counter runs only while waking from deep idle or stop
  hrc_warm_if wu ();

  hrc_sync u_sync_nmi (
    .clk(clk),
    .rst_b(rst_b),
    .pin(nmi_pin),
    .level(nmi_lvl)
  );

  hrc_sync u_sync_ez (
    .clk(clk),
    .rst_b(rst_b),
    .pin(ext_irq_zero_pin),
    .level(ez_lvl)
  );

  hrc_warmup u_warmup (
    .clk(clk),
    .rst_b(rst_b),
    .wu(wu.cnt)
  );

  assign wu.start = r.wu_start;
  assign wu.cycles = warmup_cycles;

  // best maskable request above the mask; lowest index wins a tie
  logic mk_ok;
  hrc_src_t mk_src;
  hrc_level_t mk_level;

  always_comb begin
    mk_ok = 1'b0;
    mk_src = `HRC_RST_SRC;
    mk_level = `HRC_RST_LEVEL;
    for (int i = 0; i < `HRC_NUM_MASKABLE; i++) begin
      if (irq_req[i] && (irq_level[i] > interrupt_mask_level)) begin // RULE3 RULE4
        if (!mk_ok || (irq_level[i] > mk_level)) begin
          mk_ok = 1'b1;
          mk_src = 4'(i);
          mk_level = irq_level[i];
        end
      end
    end
  end

  // service candidate among all pending requests
  logic ez_svc_ok;
  logic svc_any;
  hrc_src_t cand_src;
  hrc_level_t cand_level;

  always_comb begin
    ez_svc_ok = r.ez_pend && (ext_irq_zero_level > interrupt_mask_level);
    svc_any = 1'b1;
    cand_src = `HRC_RST_SRC;
    cand_level = `HRC_RST_LEVEL;
    if (r.nmi_pend) begin
      cand_src = `HRC_SRC_NMI; // RULE5
      cand_level = `HRC_NMI_LEVEL; // RULE12
    end else if (ez_svc_ok && (!mk_ok || (ext_irq_zero_level >= mk_level))) begin
      // ext zero wins a tie against a maskable of the same level
      cand_src = `HRC_SRC_EXT_ZERO; // RULE10
      cand_level = ext_irq_zero_level;
    end else if (mk_ok) begin
      cand_src = mk_src;
      cand_level = mk_level;
    end else begin
      svc_any = 1'b0;
    end
  end

  // edges, flag clears and wake qualification
  logic nmi_edge;
  logic ez_edge;
  logic fresh;
  logic deep;
  logic wake_ok;
  logic svc_done;
  logic clr_nmi;
  logic clr_ez;

  always_comb begin
    nmi_edge = nmi_lvl && !r.nmi_prev;
    ez_edge = ez_lvl && !r.ez_prev;
    fresh = nmi_edge || ez_edge;
    deep = (r.mode == HRC_MODE_DEEP) || (r.mode == HRC_MODE_STOP);
    // a service retires on the edge at which the core acknowledges it
    svc_done = r.svc_valid && svc_ack;
    // retiring an nmi or ext zero service clears its pending flag
    clr_nmi = svc_done && (r.svc_src == `HRC_SRC_NMI);
    clr_ez = svc_done && (r.svc_src == `HRC_SRC_EXT_ZERO);
    // deep modes ignore old flags: only an edge after entry ends the halt
    if (deep) begin
      wake_ok = fresh; // RULE13 RULE10
    end else begin
      wake_ok = r.nmi_pend || r.ez_pend || mk_ok || fresh; // RULE2 RULE6
    end
  end

  always_comb begin
    n = r;
    n.nmi_prev = nmi_lvl;
    n.ez_prev = ez_lvl;
    // pulses last one cycle; the pending flags keep every pin edge
    n.wake_pulse = 1'b0;
    n.resume_pulse = 1'b0;
    n.wu_start = 1'b0;
    // the set wins over a clear arriving in the same cycle
    n.nmi_pend = (r.nmi_pend && !clr_nmi) || nmi_edge; // RULE9
    n.ez_pend = (r.ez_pend && !clr_ez) || ez_edge; // RULE7 RULE9
    if (svc_done) begin
      n.svc_valid = 1'b0;
    end
    case (r.state)
      // running: hand out services, or take a halt when none is due
      HRC_ST_RUN: begin
        n.halted = 1'b0;
        n.sysclk_en = 1'b1;
        n.osc_en = 1'b1;
        // a pin edge in this cycle reaches its flag only at the edge, so the choice waits one cycle
        if (!r.svc_valid && !svc_done && svc_any && !fresh) begin
          n.svc_valid = 1'b1; // RULE10
          n.svc_src = cand_src;
          n.svc_level = cand_level;
        end else if (halt_req && !r.svc_valid && !svc_any) begin
          n.mode = halt_mode;
          n.halted = 1'b1;
          n.held = 1'b0;
          if ((halt_mode == HRC_MODE_DEEP) || (halt_mode == HRC_MODE_STOP)) begin
            n.state = HRC_ST_ENTER;
            n.enter_cnt = entry_load;
          end else begin
            n.state = HRC_ST_HALT;
          end
        end
      end

      HRC_ST_ENTER: begin
        // requests here only latch; they cannot end the halt
        if (fresh) begin
          n.held = 1'b1; // RULE8 RULE9
        end
        // once entry completes the system clock stops, and in stop the oscillator too
        if (r.enter_cnt == `HRC_RST_CNT) begin
          n.state = HRC_ST_HALT;
          n.sysclk_en = 1'b0;
          n.osc_en = (r.mode != HRC_MODE_STOP);
        end else begin
          n.enter_cnt = r.enter_cnt - 2'h1;
        end
      end

      // halted: only a qualifying request ends it
      HRC_ST_HALT: begin
        if (wake_ok) begin // RULE1
          if (deep) begin
            // the oscillator restarts first; the system clock waits for the warmup
            n.state = HRC_ST_WARM; // RULE11
            n.osc_en = 1'b1;
            n.wu_start = 1'b1;
          end else begin
            n.state = HRC_ST_WAKE;
          end
        end
      end

      // oscillator running, system clock held off until the warmup ends
      HRC_ST_WARM: begin
        if (wu.done) begin
          n.state = HRC_ST_WAKE; // RULE11
          n.sysclk_en = 1'b1;
        end
      end

      // release: service by priority, or resume after the halt
      HRC_ST_WAKE: begin
        if (fresh) begin
          // a pin edge now is not in the candidate yet; release one cycle later
          n.state = HRC_ST_WAKE; // RULE10
        end else begin
          n.state = HRC_ST_RUN;
          n.halted = 1'b0;
          n.wake_pulse = 1'b1;
          n.held = 1'b0;
          if (svc_any) begin
            n.svc_valid = 1'b1; // RULE3 RULE5 RULE10
            n.svc_src = cand_src;
            n.svc_level = cand_level;
          end else begin
            n.resume_pulse = 1'b1; // RULE6
          end
        end
      end

      // unused codes fall back to run
      default: begin
        n.state = HRC_ST_RUN;
      end
    endcase
  end

  // reset initialises every setting here; ram lives outside this block and is untouched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r.state <= HRC_ST_RUN; // RULE1 RULE14
      r.mode <= HRC_MODE_RUN;
      r.enter_cnt <= `HRC_RST_CNT;
      r.nmi_prev <= `HRC_RST_FLAG;
      r.ez_prev <= `HRC_RST_FLAG;
      r.nmi_pend <= `HRC_RST_FLAG;
      r.ez_pend <= `HRC_RST_FLAG;
      r.held <= `HRC_RST_FLAG;
      r.svc_valid <= `HRC_RST_FLAG;
      r.svc_src <= `HRC_RST_SRC;
      r.svc_level <= `HRC_RST_LEVEL;
      r.wake_pulse <= `HRC_RST_FLAG;
      r.resume_pulse <= `HRC_RST_FLAG;
      r.halted <= `HRC_RST_FLAG;
      r.sysclk_en <= `HRC_RST_CLK_EN;
      r.osc_en <= `HRC_RST_CLK_EN;
      r.wu_start <= `HRC_RST_FLAG;
    end else begin
      r <= n;
    end
  end

  assign core_halted = r.halted;
  assign core_wake = r.wake_pulse;
  assign core_resume_next = r.resume_pulse;
  assign svc_valid = r.svc_valid;
  assign svc_src = r.svc_src;
  assign svc_level = r.svc_level;
  assign nmi_flag = r.nmi_pend;
  assign ext_irq_zero_flag = r.ez_pend;
  assign sysclk_en = r.sysclk_en;
  assign osc_en = r.osc_en;

endmodule // hrc_top

// *** sim/hrc_top_checker.sv ***
// checker of the halt release controller, bound to its top
// assumes one clock domain and an active low reset
`include "hrc_params.svh"
module hrc_top_checker
  import hrc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // watched ports
  input wire hrc_level_t interrupt_mask_level,
  input wire logic core_halted,
  input wire logic core_wake,
  input wire logic core_resume_next,
  input wire logic svc_valid,
  input wire hrc_src_t svc_src,
  input wire hrc_level_t svc_level,
  input wire logic nmi_flag,
  input wire logic ext_irq_zero_flag,
  input wire logic sysclk_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  halt_end_a: assert property ($fell(core_halted) |-> core_wake)
    else $error("halt end without wake");
  resume_bare_a: assert property (core_resume_next |-> core_wake && !svc_valid)
    else $error("resume with service");
  ez_flag_kept_a: assert property (core_resume_next |-> ext_irq_zero_flag)
    else $error("ext zero flag lost");
  nmi_level_a: assert property (svc_valid && svc_src == `HRC_SRC_NMI |-> svc_level == `HRC_NMI_LEVEL)
    else $error("nmi level wrong");
  nmi_first_a: assert property (core_wake && nmi_flag |-> svc_valid && svc_src == `HRC_SRC_NMI)
    else $error("nmi not first");
  above_mask_a: assert property ($rose(svc_valid) && svc_src < 4'h8 |-> svc_level > interrupt_mask_level)
    else $error("served under mask");
  wake_clocked_a: assert property (core_wake |-> sysclk_en)
    else $error("wake before clock");
  warm_wake_a: assert property ($rose(sysclk_en) |-> ##[0:2] core_wake)
    else $error("clock without wake");
  cover property (core_resume_next);
  cover property ($rose(sysclk_en));
  cover property (svc_valid && svc_src == `HRC_SRC_NMI);
endmodule // hrc_top_checker

bind hrc_top hrc_top_checker i_chk (.clk, .rst_b, .interrupt_mask_level, .core_halted, .core_wake,
  .core_resume_next, .svc_valid, .svc_src, .svc_level, .nmi_flag, .ext_irq_zero_flag, .sysclk_en);

// *** sim/hrc_core_model.sv ***
// core and maskable source model: acks each service a few cycles late
// assumes the bench raises requests by writing irq_req
module hrc_core_model
  import hrc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // service handshake
  input wire logic svc_valid,
  input wire hrc_src_t svc_src,
  output logic svc_ack,
  // maskable requests
  output logic [7:0] irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial begin
    svc_ack = 1'b0;
    irq_req = 8'h00;
  end
  // a source holds its request until its service is acked
  always @(posedge clk) begin
    #1;
    svc_ack = 1'b0;
    if (!svc_valid || !rst_b) begin
      cnt = 0;
    end else if (++cnt == 3) begin
      svc_ack = 1'b1;
      cnt = 0;
      if (svc_src < 4'h8) irq_req[svc_src[2:0]] = 1'b0;
    end
  end
endmodule // hrc_core_model

// *** sim/hrc_top_test.sv ***
// bench of the halt release controller: mask table, then hand tests
// assumes the core model acks services on its own
module hrc_top_test
  import hrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {hrc_level_t mask; hrc_level_t lv; logic wake;} hrc_row_s;
  logic clk = 1'b0, rst_b = 1'b0, nmi_pin = 1'b0, ez_pin = 1'b0, halt_req = 1'b0, svc_ack;
  logic halted, wake, resume, sv, nflag, eflag, sclk, osc;
  logic [7:0] irq_req;
  logic [7:0][2:0] irq_lv = '0;
  hrc_level_t ez_lv = 3'h0, mask = 3'h0, lvl;
  hrc_mode_e mode = HRC_MODE_RUN;
  hrc_warm_t warm = 16'h0006;
  hrc_src_t src;
  int n_errors = 0, n_compared = 0, n = 0;
  hrc_row_s rows [5] = '{'{3'h2, 3'h5, 1'b1}, '{3'h5, 3'h3, 1'b0}, '{3'h4, 3'h4, 1'b0}, '{3'h0, 3'h1, 1'b1},
    '{3'h6, 3'h7, 1'b1}};

  hrc_top i_dut (.clk, .rst_b, .nmi_pin, .ext_irq_zero_pin(ez_pin), .ext_irq_zero_level(ez_lv), .irq_req,
    .irq_level(irq_lv), .interrupt_mask_level(mask), .halt_req, .halt_mode(mode), .svc_ack,
    .warmup_cycles(warm), .core_halted(halted), .core_wake(wake), .core_resume_next(resume),
    .svc_valid(sv), .svc_src(src), .svc_level(lvl), .nmi_flag(nflag), .ext_irq_zero_flag(eflag),
    .sysclk_en(sclk), .osc_en(osc));
  hrc_core_model i_core (.clk, .rst_b, .svc_valid(sv), .svc_src(src), .svc_ack, .irq_req);

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic halt(input hrc_mode_e m);
    mode = m;
    halt_req = 1'b1;
    tick(1);
    halt_req = 1'b0;
  endtask

  task automatic pin(input bit is_nmi);
    if (is_nmi) nmi_pin = 1'b1;
    else ez_pin = 1'b1;
  endtask

  // k 0: wake pulse, 1: service up, 2: service gone; pins drop after 5 cycles
  task automatic wt(input int k, input int lim);
    n = 0;
    while (n < lim && !(k == 0 ? wake : k == 1 ? sv : !sv)) begin
      tick(1);
      n++;
      if (n == 5) {nmi_pin, ez_pin} = 2'b00;
    end
  endtask

  initial begin
    #(50 * 4000);
    n_errors++;
    finish_test();
  end

  initial begin
    tick(8);
    rst_b = 1'b1;
    tick(1);
    chk("after reset", 4'h3, {halted, sv, sclk, osc});
    foreach (rows[i]) begin
      mask = rows[i].mask;
      irq_lv[2] = rows[i].lv;
      halt(hrc_mode_e'(i % 2));
      tick(2);
      i_core.irq_req[2] = 1'b1;
      wt(0, 12);
      chk("wake", rows[i].wake, wake);
      if (!rows[i].wake) begin
        pin(1);
        wt(0, 12);
      end
      chk("src", rows[i].wake ? 4'h2 : 4'h9, src);
      chk("level", rows[i].wake ? rows[i].lv : 3'h7, lvl);
      wt(2, 20);
      i_core.irq_req[2] = 1'b0;
      tick(3);
      $display("row %0d done", i);
    end
    mask = 3'h7;
    ez_lv = 3'h3;
    halt(HRC_MODE_RUN);
    tick(2);
    pin(0);
    wt(0, 12);
    chk("ez resume", 4'hd, {wake, resume, sv, eflag});
    mask = 3'h2;
    wt(1, 10);
    chk("ez served", 4'h8, src);
    wt(2, 20);
    $display("ext zero test done");
    mask = 3'h1;
    irq_lv[3] = 3'h6;
    halt(HRC_MODE_DEEP);
    tick(6);
    chk("deep clocks", 4'h5, {halted, sclk, osc});
    i_core.irq_req[3] = 1'b1;
    wt(0, 12);
    chk("deep stays", 4'h0, wake);
    pin(1);
    wt(0, 40);
    chk("warmup", 4'h1, n > 10);
    chk("nmi first", 4'h9, src);
    chk("nmi flag", 4'h1, nflag);
    wt(2, 20);
    wt(1, 10);
    chk("maskable next", 4'h3, src);
    wt(2, 20);
    $display("deep idle test done");
    mask = 3'h0;
    ez_lv = 3'h2;
    pin(0);
    tick(1);
    halt(HRC_MODE_STOP);
    wt(0, 12);
    chk("entry held", 4'h1, {wake, eflag});
    pin(1);
    wt(0, 40);
    chk("new first", 4'h9, src);
    wt(2, 20);
    wt(1, 10);
    chk("held next", 4'h8, src);
    wt(2, 20);
    $display("stop entry test done");
    halt(HRC_MODE_STOP);
    tick(6);
    rst_b = 1'b0;
    tick(1);
    chk("reset in stop", 4'h3, {halted, sv, sclk, osc});
    rst_b = 1'b1;
    tick(2);
    chk("after release", 4'h3, {halted, sv, sclk, osc});
    $display("reset test done");
    finish_test();
  end
endmodule // hrc_top_test
